// ===== verilog/tpl_defs.vh
// tpl_defs.vh: register offsets, field positions and reset values for the
// test pattern and loopback block.
// assumes: included by bare name; holds definitions only.
`ifndef TPL_DEFS_VH
`define TPL_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define TPL_ADDR_W 8
`define TPL_OFF_MASTER_DIAG 8'h0a
`define TPL_OFF_PAT_CTRL 8'h40
`define TPL_OFF_PAT_LEN 8'h41
`define TPL_OFF_PAT_TAP 8'h42
`define TPL_OFF_SEED_ONE 8'h43
`define TPL_OFF_SEED_TWO 8'h44
`define TPL_OFF_SEED_THREE 8'h45
`define TPL_OFF_SEED_FOUR 8'h46

// ****************************************
// master diagnostics fields
// ****************************************
`define TPL_DIAG_LINE_BIT 0
`define TPL_DIAG_PAYLOAD_BIT 1
`define TPL_DIAG_DIAG_DIGITAL_LOOP_ENABLE_BIT 2
`define TPL_DIAG_RECEIVE_UNIPOLAR_SELECT_BIT 3
`define TPL_DIAG_TRANSMIT_UNIPOLAR_SELECT_BIT 4
`define TPL_DIAG_CHLOOP_BIT 5
`define TPL_DIAG_SIGINS_BIT 6
`define TPL_DIAG_TXELST_BIT 7

// ****************************************
// pattern control fields
// ****************************************
`define TPL_CTRL_PS_BIT 0
`define TPL_CTRL_QUASI_RANDOM_SELECT_BIT 1
`define TPL_CTRL_TRANSMIT_INVERT_BIT 2
`define TPL_CTRL_RECEIVE_INVERT_BIT 3
`define TPL_CTRL_LOAD_BIT 4
`define TPL_CTRL_EN_BIT 5

// ****************************************
// reset values and quasi-random zero-run limit
// ****************************************
`define TPL_RST_DIAG 8'h00
`define TPL_RST_CTRL 8'h00
`define TPL_RST_LEN 5'h00
`define TPL_RST_TAP 5'h00
`define TPL_RST_SEED 8'hff
`define TPL_QUASI_RANDOM_SELECT_LIMIT 5'h0e

`endif

// ===== verilog/tpl_pattern_gen.v
// tpl_pattern_gen.v: 32-stage shift register with a single xor feedback gate.
// assumes: one clock, async active-low reset, controls steady from registers.
`timescale 1ns/1ns
`include "tpl_defs.vh"

module tpl_pattern_gen (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // control
    input wire i_enable,
    input wire i_load,
    input wire i_structure_select,
    input wire i_quasi_random_select,
    input wire [4:0] i_shift_length_field,
    input wire [4:0] i_feedback_tap_field,
    input wire [31:0] i_seed,
    // pattern
    output wire o_bit
);

    reg [31:0] sr_q;
    reg [31:0] sr_d;
    reg [4:0] zrun_q;
    wire last_w;
    wire tap_w;
    wire fb_w;
    wire force_w;

    assign last_w = sr_q[i_shift_length_field];
    assign tap_w = sr_q[i_feedback_tap_field];
    // the one feedback gate; recirculate mode closes the loop unchanged
    assign fb_w = i_structure_select ? last_w : (last_w ^ tap_w);

    always @* begin
        sr_d = {sr_q[30:0], fb_w};
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sr_q <= 32'hffffffff;
            zrun_q <= 5'h00;
        end else if (i_load) begin
            sr_q <= i_seed;
            zrun_q <= 5'h00;
        end else if (i_enable) begin
            sr_q <= sr_d;
            // a forced one ends the run, so the limit repeats rather than sticks
            if (last_w || force_w)
                zrun_q <= 5'h00;
            else if (zrun_q != 5'h1f)
                zrun_q <= zrun_q + 5'h01;
        end
    end

    // quasi-random limits runs of zeros by forcing a one after the limit
    assign force_w = i_quasi_random_select && (zrun_q >= `TPL_QUASI_RANDOM_SELECT_LIMIT);
    assign o_bit = force_w ? 1'b1 : last_w;

endmodule

// ===== verilog/tpl_loop_mux.v
// tpl_loop_mux.v: combinational steering of the four loopback paths.
// assumes: all inputs already on i_clk; caller registers the outputs.
`timescale 1ns/1ns

module tpl_loop_mux (
    // mode
    input wire i_line_loop_enable,
    input wire i_payload_loop_enable,
    input wire i_diag_digital_loop_enable,
    input wire i_receive_unipolar_select,
    input wire i_chan_loop,
    input wire i_sig_insert,
    input wire i_sig_slot,
    input wire i_sig_bit,
    // sources
    input wire i_cdr_data,
    input wire i_receive_digital_input_sampled,
    input wire i_rx_pos,
    input wire i_rx_neg,
    input wire i_transmit_jitter_attenuator_pos,
    input wire i_transmit_jitter_attenuator_neg,
    input wire i_transmit_jitter_attenuator_nrz,
    input wire i_relst_data,
    input wire i_bp_tx_data,
    input wire i_tx_payload,
    // steered
    output reg o_transmit_jitter_attenuator_in,
    output reg o_pcm_in,
    output reg o_cdr_pos,
    output reg o_cdr_neg,
    output reg o_receive_jitter_attenuator_in
);

    reg pay_w;

    always @* begin
        // default: no cross-connection
        o_transmit_jitter_attenuator_in = i_tx_payload;
        o_cdr_pos = i_rx_pos;
        o_cdr_neg = i_rx_neg;
        o_receive_jitter_attenuator_in = i_receive_digital_input_sampled;
        pay_w = i_bp_tx_data;
        if (i_payload_loop_enable)
            pay_w = i_relst_data;
        else if (i_chan_loop)
            pay_w = i_relst_data;
        // signaling insertion wins over looped data
        o_pcm_in = (i_sig_insert && i_sig_slot) ? i_sig_bit : pay_w;
        if (i_line_loop_enable)
            o_transmit_jitter_attenuator_in = i_receive_unipolar_select ? i_receive_digital_input_sampled : i_cdr_data;
        if (i_diag_digital_loop_enable) begin
            if (i_receive_unipolar_select) begin
                o_receive_jitter_attenuator_in = i_transmit_jitter_attenuator_nrz;
            end else begin
                o_cdr_pos = i_transmit_jitter_attenuator_pos;
                o_cdr_neg = i_transmit_jitter_attenuator_neg;
            end
        end
    end

endmodule

// ===== verilog/tpl_test_loop.v
// tpl_test_loop.v: pattern generator registers and loopback steering top.
// assumes: microprocessor port synchronous to i_clk; line pins asynchronous
// and synchronised here; store data, frame pulses and clocks come from the framer.
`timescale 1ns/1ns
`include "tpl_defs.vh"

module tpl_test_loop (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // microprocessor port
    input wire i_cs,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    output wire [7:0] o_rdata,
    // line side pins
    input wire i_receive_digital_input,
    input wire i_rx_pos,
    input wire i_rx_neg,
    // framer sources
    input wire i_cdr_data,
    input wire i_transmit_jitter_attenuator_pos,
    input wire i_transmit_jitter_attenuator_neg,
    input wire i_transmit_jitter_attenuator_nrz,
    input wire i_relst_data,
    input wire i_bp_tx_data,
    input wire i_tx_payload,
    input wire i_tx_clk_en,
    input wire i_tx_frame_align,
    input wire i_backplane_tx_frame_pulse,
    input wire i_sig_slot,
    input wire i_sig_bit,
    input wire i_chan_loop_slot,
    // steered and pattern outputs
    output wire o_transmit_jitter_attenuator_in,
    output wire o_pcm_in,
    output wire o_cdr_pos,
    output wire o_cdr_neg,
    output wire o_receive_jitter_attenuator_in,
    output wire o_relst_rd_en,
    output wire o_relst_frame_sync,
    output wire o_pattern_tx,
    output wire o_pattern_rx
);

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] diag_q;
    reg [7:0] ctrl_q;
    reg [4:0] len_q;
    reg [4:0] tap_q;
    reg [7:0] seed1_q;
    reg [7:0] seed2_q;
    reg [7:0] seed3_q;
    reg [7:0] seed4_q;
    reg [7:0] rdata_q;
    reg load_q;
    wire wr_w;

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign wr_w = i_cs & i_wr;

    // any loop bit may be written at any time
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            diag_q <= `TPL_RST_DIAG;
            ctrl_q <= `TPL_RST_CTRL;
            len_q <= `TPL_RST_LEN;
            tap_q <= `TPL_RST_TAP;
            seed1_q <= `TPL_RST_SEED;
            seed2_q <= `TPL_RST_SEED;
            seed3_q <= `TPL_RST_SEED;
            seed4_q <= `TPL_RST_SEED;
            load_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (wr_w && hit(i_addr, `TPL_OFF_MASTER_DIAG))
                diag_q <= i_wdata;
            if (wr_w && hit(i_addr, `TPL_OFF_PAT_CTRL)) begin
                // load bit is self-clearing; it strobes the seed in
                ctrl_q <= i_wdata & 8'hef;
                load_q <= i_wdata[`TPL_CTRL_LOAD_BIT];
            end
            if (wr_w && hit(i_addr, `TPL_OFF_PAT_LEN))
                len_q <= i_wdata[4:0];
            if (wr_w && hit(i_addr, `TPL_OFF_PAT_TAP))
                tap_q <= i_wdata[4:0];
            if (wr_w && hit(i_addr, `TPL_OFF_SEED_ONE))
                seed1_q <= i_wdata;
            if (wr_w && hit(i_addr, `TPL_OFF_SEED_TWO))
                seed2_q <= i_wdata;
            if (wr_w && hit(i_addr, `TPL_OFF_SEED_THREE))
                seed3_q <= i_wdata;
            if (wr_w && hit(i_addr, `TPL_OFF_SEED_FOUR))
                seed4_q <= i_wdata;
        end
    end

    // ****************************************
    // read back
    // ****************************************
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= 8'h00;
        end else if (i_cs && i_rd) begin
            case (i_addr)
                `TPL_OFF_MASTER_DIAG: rdata_q <= diag_q;
                `TPL_OFF_PAT_CTRL: rdata_q <= ctrl_q;
                `TPL_OFF_PAT_LEN: rdata_q <= {3'h0, len_q};
                `TPL_OFF_PAT_TAP: rdata_q <= {3'h0, tap_q};
                `TPL_OFF_SEED_ONE: rdata_q <= seed1_q;
                `TPL_OFF_SEED_TWO: rdata_q <= seed2_q;
                `TPL_OFF_SEED_THREE: rdata_q <= seed3_q;
                `TPL_OFF_SEED_FOUR: rdata_q <= seed4_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign o_rdata = rdata_q;

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {i_receive_digital_input, i_rx_pos, i_rx_neg};
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // pattern generator
    // ****************************************
    wire pat_w;
    tpl_pattern_gen u_gen (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_enable(ctrl_q[`TPL_CTRL_EN_BIT]),
        .i_load(load_q),
        .i_structure_select(ctrl_q[`TPL_CTRL_PS_BIT]),
        .i_quasi_random_select(ctrl_q[`TPL_CTRL_QUASI_RANDOM_SELECT_BIT]),
        .i_shift_length_field(len_q),
        .i_feedback_tap_field(tap_q),
        .i_seed({seed4_q, seed3_q, seed2_q, seed1_q}),
        .o_bit(pat_w)
    );

    // ****************************************
    // loopback steering
    // ****************************************
    wire line_loop_enable;
    wire payload_loop_enable;
    wire diag_digital_loop_enable;
    wire receive_unipolar_select;
    wire transmit_elastic_store_used;
    wire frame_src_w;
    wire transmit_jitter_attenuator_w;
    wire pcm_w;
    wire cpos_w;
    wire cneg_w;
    wire receive_jitter_attenuator_w;

    assign line_loop_enable = diag_q[`TPL_DIAG_LINE_BIT];
    assign payload_loop_enable = diag_q[`TPL_DIAG_PAYLOAD_BIT];
    assign diag_digital_loop_enable = diag_q[`TPL_DIAG_DIAG_DIGITAL_LOOP_ENABLE_BIT];
    assign receive_unipolar_select = diag_q[`TPL_DIAG_RECEIVE_UNIPOLAR_SELECT_BIT];
    assign transmit_elastic_store_used = diag_q[`TPL_DIAG_TXELST_BIT];
    // transmit store in use gives its own free-running alignment
    assign frame_src_w = transmit_elastic_store_used ? i_tx_frame_align : i_backplane_tx_frame_pulse;

    tpl_loop_mux u_mux (
        .i_line_loop_enable(line_loop_enable),
        .i_payload_loop_enable(payload_loop_enable),
        .i_diag_digital_loop_enable(diag_digital_loop_enable),
        .i_receive_unipolar_select(receive_unipolar_select),
        .i_chan_loop(diag_q[`TPL_DIAG_CHLOOP_BIT] & i_chan_loop_slot),
        .i_sig_insert(diag_q[`TPL_DIAG_SIGINS_BIT]),
        .i_sig_slot(i_sig_slot),
        .i_sig_bit(i_sig_bit),
        .i_cdr_data(i_cdr_data),
        .i_receive_digital_input_sampled(sync2_q[2]),
        .i_rx_pos(sync2_q[1]),
        .i_rx_neg(sync2_q[0]),
        .i_transmit_jitter_attenuator_pos(i_transmit_jitter_attenuator_pos),
        .i_transmit_jitter_attenuator_neg(i_transmit_jitter_attenuator_neg),
        .i_transmit_jitter_attenuator_nrz(i_transmit_jitter_attenuator_nrz),
        .i_relst_data(i_relst_data),
        .i_bp_tx_data(i_bp_tx_data),
        .i_tx_payload(i_tx_payload),
        .o_transmit_jitter_attenuator_in(transmit_jitter_attenuator_w),
        .o_pcm_in(pcm_w),
        .o_cdr_pos(cpos_w),
        .o_cdr_neg(cneg_w),
        .o_receive_jitter_attenuator_in(receive_jitter_attenuator_w)
    );

    // ****************************************
    // output registers
    // ****************************************
    reg [8:0] out_q;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_q <= 9'h000;
        end else begin
            out_q[0] <= transmit_jitter_attenuator_w;
            out_q[1] <= pcm_w;
            out_q[2] <= cpos_w;
            out_q[3] <= cneg_w;
            out_q[4] <= receive_jitter_attenuator_w;
            // store read paced by transmit clock during payload loop
            out_q[5] <= payload_loop_enable & i_tx_clk_en;
            out_q[6] <= payload_loop_enable & frame_src_w;
            out_q[7] <= pat_w ^ ctrl_q[`TPL_CTRL_TRANSMIT_INVERT_BIT];
            out_q[8] <= pat_w ^ ctrl_q[`TPL_CTRL_RECEIVE_INVERT_BIT];
        end
    end

    assign o_transmit_jitter_attenuator_in = out_q[0];
    assign o_pcm_in = out_q[1];
    assign o_cdr_pos = out_q[2];
    assign o_cdr_neg = out_q[3];
    assign o_receive_jitter_attenuator_in = out_q[4];
    assign o_relst_rd_en = out_q[5];
    assign o_relst_frame_sync = out_q[6];
    assign o_pattern_tx = out_q[7];
    assign o_pattern_rx = out_q[8];

endmodule

// ===== dv/tpl_far_end_model.sv
// tpl_far_end_model: line interface and backplane sources for the bench
// assumes: bench sets i_src; transmit strobe and frame marks free-run
`timescale 1ns/1ns
module tpl_far_end_model (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // requested levels
    input wire [12:0] i_src,
    // driven sources
    output reg [12:0] o_src,
    output wire o_tx_clk_en,
    output wire o_frame_pulse,
    output wire o_frame_align
);
    // ****
    // timing
    // ****
    reg [3:0] cnt_q;
    // attenuator divisors taken as set for loop use; data here is bit-level only
    // falling edge keeps every change clear of the sampling edge
    always @(negedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 4'h0;
            o_src <= 13'h0000;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            o_src <= i_src;
        end
    end
    assign o_tx_clk_en = cnt_q[0];
    assign o_frame_pulse = (cnt_q == 4'h0);
    assign o_frame_align = (cnt_q == 4'h8);
endmodule

// ===== dv/tpl_test_loop_assertions.sv
// tpl_test_loop_assertions: steering relations at the block ports
// assumes: bound to tpl_test_loop; diag register mirrored from bus writes
`timescale 1ns/1ns
`include "tpl_defs.vh"
module tpl_test_loop_assertions (
    // clock, reset, bus
    input wire i_clk,
    input wire i_arst_n,
    input wire i_cs,
    input wire i_wr,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    // sources
    input wire i_receive_digital_input,
    input wire i_cdr_data,
    input wire i_transmit_jitter_attenuator_pos,
    input wire i_transmit_jitter_attenuator_neg,
    input wire i_transmit_jitter_attenuator_nrz,
    input wire i_relst_data,
    input wire i_bp_tx_data,
    input wire i_tx_clk_en,
    input wire i_tx_frame_align,
    input wire i_backplane_tx_frame_pulse,
    input wire i_sig_slot,
    input wire i_sig_bit,
    // steered
    input wire o_transmit_jitter_attenuator_in,
    input wire o_pcm_in,
    input wire o_cdr_pos,
    input wire o_cdr_neg,
    input wire o_receive_jitter_attenuator_in,
    input wire o_relst_rd_en,
    input wire o_relst_frame_sync
);
    // ****
    // diag mirror
    // ****
    reg [7:0] diag_q;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            diag_q <= 8'h00;
        end else if (i_cs && i_wr && i_addr == `TPL_OFF_MASTER_DIAG) begin
            diag_q <= i_wdata;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // ****
    // properties
    // ****
    // pin path crosses two sync flops, so the mode must stand three cycles
    sequence s_dig_held;
        (diag_q[0] && diag_q[3]) [*3];
    endsequence
    property p_line_analog;
        diag_q[0] && !diag_q[3] |=> o_transmit_jitter_attenuator_in == $past(i_cdr_data);
    endproperty
    property p_line_digital;
        s_dig_held |=> o_transmit_jitter_attenuator_in == $past(i_receive_digital_input, 3);
    endproperty
    property p_payload;
        diag_q[1] && !(diag_q[6] && i_sig_slot) |=> o_pcm_in == $past(i_relst_data);
    endproperty
    property p_sig_over;
        diag_q[1] && diag_q[6] && i_sig_slot |=> o_pcm_in == $past(i_sig_bit);
    endproperty
    property p_diag_digital_loop_enable_analog;
        diag_q[2] && !diag_q[3] |=> o_cdr_pos == $past(i_transmit_jitter_attenuator_pos) && o_cdr_neg == $past(i_transmit_jitter_attenuator_neg);
    endproperty
    property p_diag_digital_loop_enable_digital;
        diag_q[2] && diag_q[3] |=> o_receive_jitter_attenuator_in == $past(i_transmit_jitter_attenuator_nrz);
    endproperty
    property p_rd_en;
        diag_q[1] |=> o_relst_rd_en == $past(i_tx_clk_en);
    endproperty
    property p_frame_store;
        diag_q[1] && diag_q[7] |=> o_relst_frame_sync == $past(i_tx_frame_align);
    endproperty
    property p_frame_bypass;
        diag_q[1] && !diag_q[7] |=> o_relst_frame_sync == $past(i_backplane_tx_frame_pulse);
    endproperty
    property p_normal;
        diag_q[1:0] == 2'b00 && !diag_q[5] && !diag_q[6] |=> o_pcm_in == $past(i_bp_tx_data);
    endproperty
    a_line_analog: assert property (p_line_analog) else $error("line loop analog data wrong");
    a_line_digital: assert property (p_line_digital) else $error("line loop digital data wrong");
    a_payload: assert property (p_payload) else $error("payload loop data wrong");
    a_sig_over: assert property (p_sig_over) else $error("signaling not inserted");
    a_diag_digital_loop_enable_analog: assert property (p_diag_digital_loop_enable_analog) else $error("dual rail loop wrong");
    a_diag_digital_loop_enable_digital: assert property (p_diag_digital_loop_enable_digital) else $error("single rail loop wrong");
    a_rd_en: assert property (p_rd_en) else $error("store read strobe wrong");
    a_frame_store: assert property (p_frame_store) else $error("frame sync not from store");
    a_frame_bypass: assert property (p_frame_bypass) else $error("frame sync not from pulse");
    a_normal: assert property (p_normal) else $error("transmit path not from backplane");
endmodule
bind tpl_test_loop tpl_test_loop_assertions u_tpl_chk (
    .i_clk, .i_arst_n, .i_cs, .i_wr, .i_addr, .i_wdata, .i_receive_digital_input, .i_cdr_data, .i_transmit_jitter_attenuator_pos,
    .i_transmit_jitter_attenuator_neg, .i_transmit_jitter_attenuator_nrz, .i_relst_data, .i_bp_tx_data, .i_tx_clk_en, .i_tx_frame_align,
    .i_backplane_tx_frame_pulse, .i_sig_slot, .i_sig_bit, .o_transmit_jitter_attenuator_in, .o_pcm_in, .o_cdr_pos,
    .o_cdr_neg, .o_receive_jitter_attenuator_in, .o_relst_rd_en, .o_relst_frame_sync
);

// ===== dv/tpl_test_loop_tb_top.sv
// tpl_test_loop_tb_top: steering table, register and pattern checks
// assumes: far-end model and bound checker compiled first; one 8 ns clock
`timescale 1ns/1ns
`include "tpl_defs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tpl_test_loop_tb_top;
    reg i_clk;
    reg i_arst_n;
    reg i_cs;
    reg i_wr;
    reg i_rd;
    reg [7:0] i_addr;
    reg [7:0] i_wdata;
    reg [12:0] src;
    reg [7:0] v;
    wire [12:0] s;
    wire [7:0] o_rdata;
    wire i_receive_digital_input, i_rx_pos, i_rx_neg, i_cdr_data, i_transmit_jitter_attenuator_pos, i_transmit_jitter_attenuator_neg, i_transmit_jitter_attenuator_nrz, i_relst_data;
    wire i_bp_tx_data, i_tx_payload, i_sig_slot, i_sig_bit, i_chan_loop_slot;
    wire i_tx_clk_en, i_tx_frame_align, i_backplane_tx_frame_pulse;
    wire o_transmit_jitter_attenuator_in, o_pcm_in, o_cdr_pos, o_cdr_neg, o_receive_jitter_attenuator_in;
    wire o_relst_rd_en, o_relst_frame_sync, o_pattern_tx, o_pattern_rx;
    integer num_errors, compares, i, k, n1, n2;
    // ****
    // tables: diag, sources, expected, mask / ctrl, len, tap, seed, cycles, ones
    // ****
    reg [30:0] rows [0:13] = '{
        {8'h01, 13'h0200, 5'h10, 5'h10}, {8'h01, 13'h1000, 5'h00, 5'h10}, {8'h09, 13'h1000, 5'h10, 5'h10},
        {8'h09, 13'h0200, 5'h00, 5'h10}, {8'h02, 13'h0020, 5'h08, 5'h08}, {8'h82, 13'h0010, 5'h00, 5'h08},
        {8'h42, 13'h0024, 5'h00, 5'h08}, {8'h42, 13'h0022, 5'h08, 5'h08}, {8'h04, 13'h0500, 5'h04, 5'h06},
        {8'h1c, 13'h0040, 5'h01, 5'h01}, {8'h05, 13'h0a80, 5'h12, 5'h16}, {8'h00, 13'h0820, 5'h04, 5'h0e},
        {8'h20, 13'h0021, 5'h08, 5'h08}, {8'h20, 13'h0020, 5'h00, 5'h08}};
    reg [79:0] prow [0:5] = '{
        {32'h010000fe, 16'h0008, 16'h0000, 16'h0000}, {32'h010000ff, 16'h0008, 16'h0008, 16'h0008},
        {32'h01070001, 16'h0010, 16'h0002, 16'h0002}, {32'h05070001, 16'h0010, 16'h000e, 16'h0002},
        {32'h0c0e0dff, 16'h7fff, 16'h3fff, 16'h3fff}, {32'h030000fe, 16'h001e, 16'h0002, 16'h0002}};
    assign {i_receive_digital_input, i_rx_pos, i_rx_neg, i_cdr_data, i_transmit_jitter_attenuator_pos, i_transmit_jitter_attenuator_neg, i_transmit_jitter_attenuator_nrz, i_relst_data,
        i_bp_tx_data, i_tx_payload, i_sig_slot, i_sig_bit, i_chan_loop_slot} = s;
    tpl_far_end_model u_tpl_far_end_model (.i_clk, .i_arst_n, .i_src(src), .o_src(s),
        .o_tx_clk_en(i_tx_clk_en), .o_frame_pulse(i_backplane_tx_frame_pulse), .o_frame_align(i_tx_frame_align));
    tpl_test_loop u_tpl_test_loop (.i_clk, .i_arst_n, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
        .i_receive_digital_input, .i_rx_pos, .i_rx_neg, .i_cdr_data, .i_transmit_jitter_attenuator_pos, .i_transmit_jitter_attenuator_neg, .i_transmit_jitter_attenuator_nrz, .i_relst_data,
        .i_bp_tx_data, .i_tx_payload, .i_tx_clk_en, .i_tx_frame_align, .i_backplane_tx_frame_pulse,
        .i_sig_slot, .i_sig_bit, .i_chan_loop_slot, .o_transmit_jitter_attenuator_in, .o_pcm_in, .o_cdr_pos, .o_cdr_neg,
        .o_receive_jitter_attenuator_in, .o_relst_rd_en, .o_relst_frame_sync, .o_pattern_tx, .o_pattern_rx);
    // ****
    // bus tasks and verdict
    // ****
    task wr(input [7:0] a, input [7:0] d);
        begin
            i_cs = 1'b1;
            i_wr = 1'b1;
            i_addr = a;
            i_wdata = d;
            @(negedge i_clk);
            i_cs = 1'b0;
            i_wr = 1'b0;
            @(negedge i_clk);
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            i_cs = 1'b1;
            i_rd = 1'b1;
            i_addr = a;
            @(negedge i_clk);
            i_cs = 1'b0;
            i_rd = 1'b0;
            d = o_rdata;
            @(negedge i_clk);
        end
    endtask
    task complete_run;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        {i_arst_n, i_cs, i_wr, i_rd, i_addr, i_wdata, src} = 0;
        num_errors = 0;
        compares = 0;
        repeat (20) @(negedge i_clk);
        i_arst_n = 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(64'h0a40414243460b47 >> (56 - 8 * i), v);
            `CHK("reset value", 8'(64'h00000000ffff0000 >> (56 - 8 * i)), v)
        end
        wr(`TPL_OFF_MASTER_DIAG, 8'ha5);
        wr(8'h0b, 8'hff);
        wr(`TPL_OFF_PAT_CTRL, 8'h1f);
        for (i = 0; i < 3; i++) begin
            rd(48'h0aa50b00400f >> (40 - 16 * i), v);
            `CHK("readback", 8'(48'h0aa50b00400f >> (32 - 16 * i)), v)
        end
        // ****
        // steering rows; sources move on the model's falling edge
        // ****
        for (i = 0; i < 14; i++) begin
            wr(`TPL_OFF_MASTER_DIAG, rows[i][30:23]);
            src <= rows[i][22:10];
            repeat (6) @(negedge i_clk);
            `CHK("steered", rows[i][9:5], {o_transmit_jitter_attenuator_in, o_pcm_in, o_cdr_pos, o_cdr_neg, o_receive_jitter_attenuator_in} & rows[i][4:0])
        end
        i_arst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_arst_n = 1'b1;
        rd(`TPL_OFF_MASTER_DIAG, v);
        `CHK("diag after reset", 8'h00, v)
        // ****
        // pattern rows: load with run off, then run and count ones
        // ****
        for (i = 0; i < 6; i++) begin
            wr(`TPL_OFF_PAT_LEN, prow[i][71:64]);
            wr(`TPL_OFF_PAT_TAP, prow[i][63:56]);
            wr(`TPL_OFF_SEED_ONE, prow[i][55:48]);
            wr(`TPL_OFF_PAT_CTRL, 8'h10);
            repeat (2) @(negedge i_clk);
            wr(`TPL_OFF_PAT_CTRL, 8'h20 | prow[i][79:72]);
            repeat (4) @(negedge i_clk);
            n1 = 0;
            n2 = 0;
            for (k = 0; k < prow[i][47:32]; k++) begin
                n1 += o_pattern_tx;
                n2 += o_pattern_rx;
                @(negedge i_clk);
            end
            `CHK("pattern tx ones", prow[i][31:16], n1[15:0])
            `CHK("pattern rx ones", prow[i][15:0], n2[15:0])
        end
        complete_run;
    end
endmodule
